// File: hdl/itk_defs.svh
/*
  Constants of the indirect time keeper: port addresses, internal register
  indexes, field positions and timing counts.
  Assumes inclusion once per compilation unit through its guard.
*/
`ifndef ITK_DEFS_SVH
`define ITK_DEFS_SVH

// host-side port addresses in the extended register space
`define ITK_PORT_CTRL_ADDR 12'hFE0
`define ITK_PORT_DATA_ADDR 12'hFE1

// internal register indexes
`define ITK_REG_SAMP_EN 5'h00
`define ITK_REG_TIME_EN 5'h01
`define ITK_REG_SAMP_STS 5'h02
`define ITK_REG_TIME_STS 5'h03
`define ITK_REG_SEC 5'h04
`define ITK_REG_MIN 5'h05
`define ITK_REG_HOUR 5'h06
`define ITK_REG_DAY_LO 5'h07
`define ITK_REG_DAY_HI 5'h08
`define ITK_REG_ALM_SEC 5'h09
`define ITK_REG_ALM_MIN 5'h0A
`define ITK_REG_ALM_HOUR 5'h0B
`define ITK_REG_ALM_DAY_LO 5'h0C
`define ITK_REG_ALM_DAY_HI 5'h0D
`define ITK_REG_SPARE_BASE 5'h10

// port control fields
`define ITK_CTRL_ADDR_LSB 3
`define ITK_CTRL_WR_BIT 2
`define ITK_CTRL_EN_BIT 0

// unlock key bit and lock pattern
`define ITK_KEY_BIT 7
`define ITK_LOCK_PATTERN 8'hA0

// reset values
`define ITK_RESET_BYTE 8'h00

// time base: 32768 reference edges per second, last count 32767
`define ITK_PRESC_TOP 16'h7FFF
`define ITK_SAMP_BASE_MASK 16'h2000
`define ITK_SEC_LAST 6'h3B
`define ITK_HOUR24_LAST 5'h17
`define ITK_HOUR12_LAST 4'hB
`define ITK_HOUR12_PM_ADD 5'h0C

// least write strobe width, in ns, and in 50 ns system clock cycles
`define ITK_CLK_PERIOD_NS 50
`define ITK_STROBE_MIN_NS 200
`define ITK_STROBE_MIN_CYC ((`ITK_STROBE_MIN_NS + `ITK_CLK_PERIOD_NS - 1) / `ITK_CLK_PERIOD_NS)

`endif

// File: hdl/itk_pkg.sv
/*
  Types of the indirect time keeper: host request carrier and unlock states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package itk_pkg;

  // one host access to the extended register space
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } itk_bus_req_t;

  // progress through the write unlock sequence
  typedef enum logic [2:0] {
    itk_lk_idle,
    itk_lk_step1,
    itk_lk_step2,
    itk_lk_step3,
    itk_lk_open
  } itk_lock_state_t;

endpackage : itk_pkg

// File: hdl/itk_time_keeper.sv
/*
  Indirect time keeper: seconds, minutes, hours and day count from a
  32.768 kHz reference, sampling timer, event flags, alarm, rate trim and
  sixteen retained bytes, reached through a control and a data port.
  Assumes the host drives bus_req on ref_clk, rd and wr as one-cycle pulses,
  and that the reference pin is asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itk_defs.svh"

// Function
// - seconds, minutes, hours advance from the 32.768 kHz reference input
// - enabled pending events drive the interrupt source 2 output
// - control bits 7..3 select the internal register
// - internal write happens when control bit 2 falls, latched address/data
// - enable bit clear makes data port reads return zero
// - data port stores write byte; reads return addressed internal register
// - sampling timer events at 4 Hz to 512 Hz, one per enable bit
// - sampling timer stopped while enable bit clear
// - only enable and status registers writable while locked
// - unlocked writes in any order; lock pattern to sts2 relocks at once
// - sixteen spare bytes at 10h..1Fh, readable whatever the lock
// - spare bytes retained, not cleared by reset
// - each sampling event sets own flag; enabled flags interrupt; write 1 clears
// - second, minute, hour, day flags; day flag at midnight rollover
// - alarm flag on minute, hour and day match; write 1 clears
// - seconds write sets trim enable, direction, amount; read gives seconds
// - clear bit holds seconds at zero until written 0; minutes writable
// - twelve hour format 0..11 plus afternoon bit, else 0..23
// - 16-bit day count and alarm day, alarm hour in 24-hour form
module itk_time_keeper
  import itk_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ref_32k,
  input wire itk_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic irq_src2
);

  // hit when the prescaler ends a period of the sampling rate n
  function automatic logic samp_hit(input logic [15:0] cnt, input int n);
    logic [15:0] mask;
    mask = (`ITK_SAMP_BASE_MASK >> n) - 16'h0001;
    return (cnt & mask) == mask;
  endfunction : samp_hit

  // current hour in 24-hour form
  function automatic logic [4:0] hour_24(input logic fmt12, input logic [4:0] h);
    logic [4:0] r;
    r = h;
    if (fmt12) begin
      r = {1'b0, h[3:0]} + (h[4] ? `ITK_HOUR12_PM_ADD : 5'h00);
    end
    return r;
  endfunction : hour_24

  logic [7:0] ctrl;
  logic [7:0] data_reg;
  logic wr_bit_q;
  logic ref_s1, ref_s2, ref_s3;
  logic [15:0] presc;
  logic [5:0] sec, min;
  logic [4:0] hour;
  logic fmt12;
  logic [15:0] day;
  logic trim_en, trim_dir;
  logic [5:0] trim_amt;
  logic sec_clr;
  logic [7:0] samp_en, samp_sts;
  logic [4:0] time_en, time_sts;
  logic [5:0] alm_sec, alm_min;
  logic [4:0] alm_hour;
  logic [15:0] alm_day;
  logic match_q;
  logic [7:0] spare [16];
  itk_lock_state_t lock_st;

  logic [4:0] sel;
  logic ctrl_en;
  logic wr_pulse;
  logic ref_tick;
  logic [15:0] presc_end;
  logic sec_tick, min_tick, hour_tick, day_tick;
  logic [4:0] next_hour;
  logic [7:0] samp_ev;
  logic alm_match;
  logic unlocked;
  logic [7:0] int_rdata;

  assign sel = ctrl[7:`ITK_CTRL_ADDR_LSB];
  assign ctrl_en = ctrl[`ITK_CTRL_EN_BIT];
  assign unlocked = (lock_st == itk_lk_open);
  // write pulse on the falling strobe bit
  assign wr_pulse = wr_bit_q & ~ctrl[`ITK_CTRL_WR_BIT];

  // host port registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= `ITK_RESET_BYTE;
      data_reg <= `ITK_RESET_BYTE;
      wr_bit_q <= 1'b0;
    end else begin
      wr_bit_q <= ctrl[`ITK_CTRL_WR_BIT];
      if (bus_req.wr && bus_req.addr == `ITK_PORT_CTRL_ADDR) begin
        ctrl <= bus_req.wdata;
      end
      if (bus_req.wr && bus_req.addr == `ITK_PORT_DATA_ADDR) begin
        data_reg <= bus_req.wdata;
      end
    end
  end

  // reference pin synchroniser and edge detect
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
    end else begin
      ref_s1 <= ref_32k;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
    end
  end
  assign ref_tick = ref_s2 & ~ref_s3;

  // trimmed second length: fast clock counts more, slow counts less
  always_comb begin
    presc_end = `ITK_PRESC_TOP;
    if (trim_en) begin
      presc_end = trim_dir ? (`ITK_PRESC_TOP + {10'h000, trim_amt})
                           : (`ITK_PRESC_TOP - {10'h000, trim_amt});
    end
  end

  assign sec_tick = ref_tick && !sec_clr && presc >= presc_end;
  assign min_tick = sec_tick && sec == `ITK_SEC_LAST;
  assign hour_tick = min_tick && min == `ITK_SEC_LAST;

  // next hour and midnight detection in both formats
  always_comb begin
    next_hour = hour + 5'h01;
    day_tick = 1'b0;
    if (fmt12) begin
      if (hour[3:0] == `ITK_HOUR12_LAST) begin
        next_hour = {~hour[4], 4'h0};
        day_tick = hour_tick && hour[4];
      end
    end else if (hour >= `ITK_HOUR24_LAST) begin
      next_hour = 5'h00;
      day_tick = hour_tick;
    end
  end

  // sampling events, only while enabled
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      samp_ev[n] = ctrl_en && ref_tick && samp_hit(presc, n);
    end
  end

  assign alm_match = min == alm_min && hour_24(fmt12, hour) == alm_hour
                     && day == alm_day;

  // prescaler; held at zero while seconds clear is set
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      presc <= 16'h0000;
    end else if (sec_clr || sec_tick) begin
      presc <= 16'h0000;
    end else if (ref_tick) begin
      presc <= presc + 16'h0001;
    end
  end

  // seconds counter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec <= 6'h00;
    end else if (sec_clr) begin
      sec <= 6'h00;
    end else if (min_tick) begin
      sec <= 6'h00;
    end else if (sec_tick) begin
      sec <= sec + 6'h01;
    end
  end

  // minutes, trim and clear control; a software write wins over a tick
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      min <= 6'h00;
      sec_clr <= 1'b0;
      trim_en <= 1'b0;
      trim_dir <= 1'b0;
      trim_amt <= 6'h00;
    end else if (wr_pulse && unlocked && sel == `ITK_REG_MIN) begin
      sec_clr <= data_reg[7];
      min <= data_reg[5:0];
    end else if (wr_pulse && unlocked && sel == `ITK_REG_SEC) begin
      trim_en <= data_reg[7];
      trim_dir <= data_reg[6];
      trim_amt <= data_reg[5:0];
    end else if (hour_tick) begin
      min <= 6'h00;
    end else if (min_tick) begin
      min <= min + 6'h01;
    end
  end

  // hours and day count
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hour <= 5'h00;
      fmt12 <= 1'b0;
      day <= 16'h0000;
    end else begin
      if (wr_pulse && unlocked && sel == `ITK_REG_HOUR) begin
        fmt12 <= data_reg[7];
        hour <= data_reg[4:0];
      end else if (hour_tick) begin
        hour <= next_hour;
      end
      if (wr_pulse && unlocked && sel == `ITK_REG_DAY_LO) begin
        day[7:0] <= data_reg;
      end else if (wr_pulse && unlocked && sel == `ITK_REG_DAY_HI) begin
        day[15:8] <= data_reg;
      end else if (day_tick) begin
        day <= day + 16'h0001;
      end
    end
  end

  // alarm settings, protected
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      alm_sec <= 6'h00;
      alm_min <= 6'h00;
      alm_hour <= 5'h00;
      alm_day <= 16'h0000;
    end else if (wr_pulse && unlocked) begin
      case (sel)
        `ITK_REG_ALM_SEC: alm_sec <= data_reg[5:0];
        `ITK_REG_ALM_MIN: alm_min <= data_reg[5:0];
        `ITK_REG_ALM_HOUR: alm_hour <= data_reg[4:0];
        `ITK_REG_ALM_DAY_LO: alm_day[7:0] <= data_reg;
        `ITK_REG_ALM_DAY_HI: alm_day[15:8] <= data_reg;
        default: alm_sec <= alm_sec;
      endcase
    end
  end

  // retained bytes, kept across system reset
  always_ff @(posedge ref_clk) begin
    if (wr_pulse && unlocked && sel[4]) begin
      spare[sel[3:0]] <= data_reg;
    end
  end

  // enable registers, always writable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      samp_en <= `ITK_RESET_BYTE;
      time_en <= 5'h00;
    end else if (wr_pulse && sel == `ITK_REG_SAMP_EN) begin
      samp_en <= data_reg;
    end else if (wr_pulse && sel == `ITK_REG_TIME_EN) begin
      time_en <= data_reg[4:0];
    end
  end

  // event flags: a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      samp_sts <= `ITK_RESET_BYTE;
      time_sts <= 5'h00;
      match_q <= 1'b1; // counts and alarm both reset to zero: no false alarm edge
    end else begin
      match_q <= alm_match;
      samp_sts <= (samp_sts & ~((wr_pulse && sel == `ITK_REG_SAMP_STS) ? data_reg : 8'h00))
                  | samp_ev;
      time_sts <= (time_sts & ~((wr_pulse && sel == `ITK_REG_TIME_STS) ? data_reg[4:0] : 5'h00))
                  | {alm_match & ~match_q, day_tick, hour_tick, min_tick, sec_tick};
    end
  end

  // unlock sequence and relock pattern
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_st <= itk_lk_idle;
    end else if (wr_pulse) begin
      if (sel == `ITK_REG_TIME_STS && data_reg == `ITK_LOCK_PATTERN) begin
        lock_st <= itk_lk_idle;
      end else if (lock_st != itk_lk_open) begin
        case (lock_st)
          itk_lk_idle: begin
            if (sel == `ITK_REG_TIME_EN && data_reg[`ITK_KEY_BIT]) begin
              lock_st <= itk_lk_step1;
            end
          end
          itk_lk_step1: begin
            if (sel == `ITK_REG_TIME_STS && !data_reg[`ITK_KEY_BIT]) begin
              lock_st <= itk_lk_step2;
            end else begin
              lock_st <= itk_lk_idle;
            end
          end
          itk_lk_step2: begin
            if (sel == `ITK_REG_TIME_EN && !data_reg[`ITK_KEY_BIT]) begin
              lock_st <= itk_lk_step3;
            end else begin
              lock_st <= itk_lk_idle;
            end
          end
          itk_lk_step3: begin
            if (sel == `ITK_REG_TIME_STS && data_reg[`ITK_KEY_BIT]) begin
              lock_st <= itk_lk_open;
            end else begin
              lock_st <= itk_lk_idle;
            end
          end
          default: lock_st <= itk_lk_idle;
        endcase
      end
    end
  end

  // internal read selection
  always_comb begin
    int_rdata = 8'h00;
    case (sel)
      `ITK_REG_SAMP_EN: int_rdata = samp_en;
      `ITK_REG_TIME_EN: int_rdata = {3'h0, time_en};
      `ITK_REG_SAMP_STS: int_rdata = samp_sts;
      `ITK_REG_TIME_STS: int_rdata = {3'h0, time_sts};
      `ITK_REG_SEC: int_rdata = {2'h0, sec};
      `ITK_REG_MIN: int_rdata = {sec_clr, 1'b0, min};
      `ITK_REG_HOUR: int_rdata = {fmt12, 2'h0, hour};
      `ITK_REG_DAY_LO: int_rdata = day[7:0];
      `ITK_REG_DAY_HI: int_rdata = day[15:8];
      `ITK_REG_ALM_SEC: int_rdata = {2'h0, alm_sec};
      `ITK_REG_ALM_MIN: int_rdata = {2'h0, alm_min};
      `ITK_REG_ALM_HOUR: int_rdata = {3'h0, alm_hour};
      `ITK_REG_ALM_DAY_LO: int_rdata = alm_day[7:0];
      `ITK_REG_ALM_DAY_HI: int_rdata = alm_day[15:8];
      default: int_rdata = sel[4] ? spare[sel[3:0]] : 8'h00;
    endcase
  end

  // host read data and interrupt, registered
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= `ITK_RESET_BYTE;
      irq_src2 <= 1'b0;
    end else begin
      irq_src2 <= |(samp_sts & samp_en) | |(time_sts & time_en);
      bus_rdata <= 8'h00;
      if (bus_req.rd && bus_req.addr == `ITK_PORT_CTRL_ADDR) begin
        bus_rdata <= ctrl;
      end else if (bus_req.rd && bus_req.addr == `ITK_PORT_DATA_ADDR) begin
        bus_rdata <= ctrl_en ? int_rdata : 8'h00;
      end
    end
  end

  a_irq_gating: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 irq_src2 == ($past(|(samp_sts & samp_en)) || $past(|(time_sts & time_en))))
    else $error("interrupt does not follow enabled flags");

  a_read_gated: assert property (@(posedge ref_clk) disable iff (!reset_n)
    bus_req.rd && bus_req.addr == `ITK_PORT_DATA_ADDR && !ctrl_en |=> bus_rdata == 8'h00)
    else $error("data read not zero while disabled");

  a_strobe_edge: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_pulse && sel == `ITK_REG_SAMP_EN |=> samp_en == $past(data_reg))
    else $error("write pulse did not store latched data");

  a_locked_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_pulse && !unlocked && sel == `ITK_REG_HOUR |=> $stable(fmt12))
    else $error("protected register written while locked");

  a_samp_stop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ctrl_en |=> (samp_sts & ~$past(samp_sts)) == 8'h00)
    else $error("sampling flag set while disabled");

  a_sec_wrap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sec_tick && sec == `ITK_SEC_LAST |=> sec == 6'h00 && min != $past(min) && time_sts[1])
    else $error("seconds did not wrap into minutes");

  a_hour_range: assert property (@(posedge ref_clk) disable iff (!reset_n)
    hour_tick |=> (fmt12 ? hour[3:0] <= `ITK_HOUR12_LAST : hour <= `ITK_HOUR24_LAST))
    else $error("hour counter out of range");

  a_flag_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_pulse && sel == `ITK_REG_SAMP_STS && data_reg[0] && !samp_ev[0] |=> !samp_sts[0])
    else $error("sampling flag not cleared by write one");

  a_relock_now: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_pulse && sel == `ITK_REG_TIME_STS && data_reg == `ITK_LOCK_PATTERN |=> !unlocked)
    else $error("lock pattern did not relock");

  a_midnight_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    day_tick |=> time_sts[3] && hour[3:0] == 4'h0)
    else $error("day flag missing at midnight");

endmodule : itk_time_keeper
`default_nettype wire

// File: verif/itk_host_model.sv
/*
  Host firmware model for the indirect time keeper: drives the control and
  data ports with one-cycle write and read pulses and forms internal writes.
  Assumes a 50 ns ref_clk and a design that samples bus_req on rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itk_defs.svh"
module itk_host_model
  import itk_pkg::*;
(
  input wire logic ref_clk,
  output var itk_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata
);
  logic en_bit;

  // idle bus from time zero
  initial begin
    bus_req = '0;
    en_bit = 1'b0;
  end

  // one write pulse, then scrambled idle lines
  task automatic port_write(input logic [11:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    bus_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : port_write

  // one read pulse, answer taken in the following cycle
  task automatic port_read(input logic [11:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    bus_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    d = bus_rdata;
  endtask : port_read

  // output enable kept for every later control write
  task automatic set_enable(input logic b);
    en_bit = b;
    port_write(`ITK_PORT_CTRL_ADDR, {7'h00, b});
  endtask : set_enable

  // data first, strobe up, hold, strobe down
  task automatic internal_write(input logic [4:0] idx, input logic [7:0] d);
    port_write(`ITK_PORT_DATA_ADDR, d);
    port_write(`ITK_PORT_CTRL_ADDR, {idx, 1'b1, 1'b0, en_bit});
    repeat (`ITK_STROBE_MIN_CYC) @(negedge ref_clk);
    port_write(`ITK_PORT_CTRL_ADDR, {idx, 1'b0, 1'b0, en_bit});
    repeat (4) @(negedge ref_clk);
  endtask : internal_write

  // select the register, then read the data port
  task automatic internal_read(input logic [4:0] idx, output logic [7:0] d);
    port_write(`ITK_PORT_CTRL_ADDR, {idx, 1'b0, 1'b0, en_bit});
    port_read(`ITK_PORT_DATA_ADDR, d);
  endtask : internal_read
endmodule : itk_host_model
`default_nettype wire

// File: verif/itk_time_keeper_test.sv
/*
  Self-checking testbench of the indirect time keeper: register access,
  write lock, alarm, trim, sampling rates and sampling stop.
  Assumes the reference pin may run at a scaled rate of one edge in two clocks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itk_defs.svh"
module itk_time_keeper_test;
  logic ref_clk;
  logic reset_n;
  logic ref_32k = 1'b0;
  time rise_t;
  logic irq_seen;
  itk_pkg::itk_bus_req_t bus_req;
  logic [7:0] bus_rdata;
  logic irq_src2;
  int miscompares;
  int check_count;

  itk_time_keeper u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .ref_32k(ref_32k),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .irq_src2(irq_src2)
  );

  itk_host_model u_host (.ref_clk(ref_clk), .bus_req(bus_req), .bus_rdata(bus_rdata));

  // system clock, 50 ns
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // scaled reference: one rising edge every two clocks
  always @(negedge ref_clk) ref_32k <= ~ref_32k;

  // time of each interrupt rise, whether or not a task is polling
  always @(negedge ref_clk) begin
    if (irq_src2 === 1'b1 && irq_seen !== 1'b1) rise_t = $time;
    irq_seen = irq_src2;
  end

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic iw(input logic [4:0] idx, input logic [7:0] d);
    u_host.internal_write(idx, d);
  endtask : iw

  // masked internal read compare
  task automatic ir(input logic [4:0] idx, input logic [7:0] exp, input logic [7:0] m);
    logic [7:0] d;
    u_host.internal_read(idx, d);
    check({24'h0, d & m}, {24'h0, exp}, "internal register");
  endtask : ir

  // bounded wait for the interrupt level
  task automatic wait_irq(input int limit);
    int n;
    n = 0;
    while (irq_src2 !== 1'b1 && n < limit) begin
      @(negedge ref_clk);
      n++;
    end
    check({31'h0, irq_src2}, 32'h1, "interrupt raised");
  endtask : wait_irq

  task automatic t_reset_values;
    u_host.set_enable(1'b1);
    for (int i = 0; i < 16; i++) ir(5'(i), 8'h00, 8'hFF);
    $display("done: reset values");
  endtask : t_reset_values

  task automatic t_lock;
    logic [7:0] d;
    iw(5'h06, 8'h05);
    ir(5'h06, 8'h00, 8'hFF);
    iw(5'h00, 8'h5A);
    ir(5'h00, 8'h5A, 8'hFF);
    iw(5'h00, 8'h00);
    iw(5'h01, 8'h80);
    iw(5'h03, 8'h00);
    iw(5'h01, 8'h00);
    iw(5'h03, 8'h80);
    iw(5'h05, 8'h81);
    ir(5'h04, 8'h00, 8'hFF);
    iw(5'h05, 8'h01);
    ir(5'h05, 8'h01, 8'h3F);
    iw(5'h01, 8'h10);
    iw(5'h0A, 8'h01);
    check({31'h0, irq_src2}, 32'h1, "alarm interrupt");
    ir(5'h03, 8'h10, 8'h1F);
    iw(5'h03, 8'h10);
    ir(5'h03, 8'h00, 8'h1F);
    check({31'h0, irq_src2}, 32'h0, "alarm interrupt cleared");
    iw(5'h01, 8'h00);
    iw(5'h04, 8'hC5);
    ir(5'h04, 8'h00, 8'hFF);
    iw(5'h04, 8'h00); // trim off, sample periods stay exact
    iw(5'h06, 8'h8B);
    ir(5'h06, 8'h8B, 8'h9F);
    iw(5'h07, 8'h34);
    iw(5'h08, 8'h12);
    ir(5'h07, 8'h34, 8'hFF);
    ir(5'h08, 8'h12, 8'hFF);
    for (int i = 0; i < 16; i++) iw(5'h10 + 5'(i), 8'hC0 + 8'(i));
    iw(5'h03, `ITK_LOCK_PATTERN);
    iw(5'h06, 8'h05);
    ir(5'h06, 8'h8B, 8'h9F);
    for (int i = 0; i < 16; i++) ir(5'h10 + 5'(i), 8'hC0 + 8'(i), 8'hFF);
    u_host.set_enable(1'b0);
    ir(5'h06, 8'h00, 8'hFF);
    u_host.set_enable(1'b1);
    ir(5'h06, 8'h8B, 8'h9F);
    u_host.port_read(`ITK_PORT_CTRL_ADDR, d);
    check({24'h0, d}, 32'h31, "control readback");
    u_host.port_read(12'hFE2, d);
    check({24'h0, d}, 32'h0, "unmapped port");
    $display("done: lock and registers");
  endtask : t_lock

  // period of each sampling rate, in clocks
  task automatic t_sample_rates;
    time t0;
    for (int n = 7; n >= 0; n--) begin
      iw(5'h00, 8'h01 << n);
      iw(5'h02, 8'hFF);
      wait_irq(2 * (8192 >> n) + 64);
      @(negedge ref_clk);
      t0 = rise_t;
      iw(5'h02, 8'h01 << n);
      check({31'h0, irq_src2}, 32'h0, "flag cleared");
      wait_irq(2 * (8192 >> n) + 64);
      @(negedge ref_clk);
      check(32'((rise_t - t0) / 50), 2 * (8192 >> n), "sample period");
    end
    $display("done: sampling rates");
  endtask : t_sample_rates

  task automatic t_sample_stop;
    int highs;
    highs = 0;
    iw(5'h00, 8'h80);
    u_host.set_enable(1'b0);
    iw(5'h02, 8'hFF);
    repeat (400) begin
      @(negedge ref_clk);
      if (irq_src2 !== 1'b0) highs++;
    end
    check(32'(highs), 32'h0, "timer stopped");
    u_host.set_enable(1'b1);
    wait_irq(200);
    iw(5'h00, 8'h00);
    iw(5'h02, 8'hFF);
    $display("done: sampling stop");
  endtask : t_sample_stop

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    reset_n = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (12) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    t_reset_values;
    t_lock;
    t_sample_rates;
    t_sample_stop;
    tally_and_finish;
  end

  // watchdog against a hang
  initial begin
    repeat (95000) @(posedge ref_clk);
    miscompares++;
    $display("unexpected at %0t: run took too long", $time);
    tally_and_finish;
  end
endmodule : itk_time_keeper_test
`default_nettype wire
